/* File: common/alarm_consts.svh */
// constants for the t1 alarm signal control block
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_FMT 8'h04
`define OFF_STAT 8'h08
`define OFF_IEN 8'h0C
`define OFF_ICLR 8'h10
`define OFF_LIVE 8'h14

// ----------------------------------------------------------------
// control register fields and values
// ----------------------------------------------------------------
`define CTRL_W 8
`define CTRL_RST 8'h00
`define YEL_HI 5
`define YEL_LO 4
`define AIS_GEN_HI 3
`define AIS_GEN_LO 2
`define AIS_DET_HI 1
`define AIS_DET_LO 0
`define SEL_OFF 2'h0
`define SEL_UNFRAMED 2'h1
`define SEL_LEVEL 2'h2
`define SEL_FRAMED 2'h3
`define FMT_W 2
`define FMT_RST 2'h0

// ----------------------------------------------------------------
// yellow burst and pattern
// ----------------------------------------------------------------
`define YEL_BURST 8'hFF
`define YEL_PATTERN 16'hFF00
`define PAT_LAST 4'hF

// ----------------------------------------------------------------
// events: status, enable and clear share this layout
// ----------------------------------------------------------------
`define EV_W 4
`define EV_YEL_START 0
`define EV_YEL_END 1
`define EV_AIS_ON 2
`define EV_AIS_OFF 3
`define EV_RST 4'h0

`endif

/* File: common/alarm_pkg.sv */
// types shared by the alarm control block
`default_nettype none
package alarm_pkg;
  typedef enum logic [1:0] {
    fmt_sf,
    fmt_esf,
    fmt_dm,
    fmt_spare
  } line_format_t;
endpackage
`default_nettype wire

/* File: rtl/yellow_pattern_gen.sv */
// yellow alarm pattern sequencer for the facility data link
`default_nettype none
`include "alarm_consts.svh"
module yellow_pattern_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic bit_en,
  output logic pattern_bit,
  output logic pattern_done
);
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic [15:0] pattern;

  assign pattern = `YEL_PATTERN;

  // ----------------------------------------------------------------
  // bit index, parked at zero while idle so bursts start clean
  // ----------------------------------------------------------------
  always_comb begin
    idx_nxt = idx_r;
    if (hold) begin
      idx_nxt = 4'h0;
    end else if (bit_en) begin
      idx_nxt = idx_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 4'h0;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  assign pattern_bit = pattern[`PAT_LAST - idx_r];
  assign pattern_done = bit_en & ~hold & (idx_r == `PAT_LAST);
endmodule
`default_nettype wire

/* File: rtl/t1_alarm_signal_control.sv */
// t1 alarm control: apb registers, yellow and ais insertion, ais detect
`default_nettype none
`include "alarm_consts.svh"
module t1_alarm_signal_control #(
  parameter int AIS_FRAMES = 2,
  parameter int AIS_CNT_W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic tx_bit_en,
  input wire logic tx_frame_start,
  input wire logic tx_data_in,
  input wire logic tx_frame_bit,
  input wire logic tx_fdl_bit,
  input wire logic tx_ybit,
  output logic tx_data_out,
  input wire logic rx_bit_en,
  input wire logic rx_frame_start,
  input wire logic rx_data,
  input wire logic rx_frame_bit,
  output logic ais_detected
);
  localparam logic [AIS_CNT_W-1:0] AIS_MAX = AIS_FRAMES[AIS_CNT_W-1:0];

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = reg_hit(a, `OFF_CTRL) | reg_hit(a, `OFF_FMT) |
             reg_hit(a, `OFF_STAT) | reg_hit(a, `OFF_IEN) |
             reg_hit(a, `OFF_ICLR) | reg_hit(a, `OFF_LIVE);
  endfunction

  logic [`CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [`FMT_W-1:0] fmt_r, fmt_nxt;
  logic [`EV_W-1:0] ien_r, ien_nxt;
  logic [`EV_W-1:0] stat_r, stat_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [`EV_W-1:0] ev_set, ev_clr;
  logic wr_acc, rd_setup;

  // applied copies, loaded on frame boundaries
  logic [1:0] yel_sel_r, yel_sel_nxt;
  logic [1:0] ais_gen_r, ais_gen_nxt;
  logic [1:0] ais_det_r, ais_det_nxt;
  alarm_pkg::line_format_t fmt_app_r, fmt_app_nxt;

  // yellow burst state
  logic lo_d_r, lo_d_nxt;
  logic pend_r, pend_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic yel_act_r, yel_act_nxt;
  logic demand, esf, load, pat_bit, pat_done;

  // line data and ais detection
  logic tx_data_r, tx_data_nxt;
  logic zero_r, zero_nxt;
  logic [AIS_CNT_W-1:0] ones_r, ones_nxt;
  logic ais_r, ais_nxt;
  logic tx_bit, bit_zero;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  // answer in the access cycle, no wait states
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = prdata_r;
  assign irq = |(stat_r & ien_r);
  assign ais_detected = ais_r;
  assign tx_data_out = tx_data_r;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    fmt_nxt = fmt_r;
    ien_nxt = ien_r;
    ev_clr = `EV_RST;
    prdata_nxt = prdata_r;
    if (wr_acc & reg_hit(paddr, `OFF_CTRL)) begin
      ctrl_nxt = pwdata[`CTRL_W-1:0];
    end
    if (wr_acc & reg_hit(paddr, `OFF_FMT)) begin
      fmt_nxt = pwdata[`FMT_W-1:0];
    end
    if (wr_acc & reg_hit(paddr, `OFF_IEN)) begin
      ien_nxt = pwdata[`EV_W-1:0];
    end
    if (wr_acc & reg_hit(paddr, `OFF_ICLR)) begin
      ev_clr = pwdata[`EV_W-1:0];
    end
    if (rd_setup) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `OFF_CTRL: prdata_nxt[`CTRL_W-1:0] = ctrl_r;
        `OFF_FMT: prdata_nxt[`FMT_W-1:0] = fmt_r;
        `OFF_STAT: prdata_nxt[`EV_W-1:0] = stat_r;
        `OFF_IEN: prdata_nxt[`EV_W-1:0] = ien_r;
        `OFF_LIVE: prdata_nxt[3:0] = {ais_r, yel_act_r, yel_sel_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // set beats clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `EV_W; gi = gi + 1) begin : g_stat
      assign stat_nxt[gi] = ev_set[gi] | (stat_r[gi] & ~ev_clr[gi]);
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `CTRL_RST;
      fmt_r <= `FMT_RST;
      ien_r <= `EV_RST;
      stat_r <= `EV_RST;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      fmt_r <= fmt_nxt;
      ien_r <= ien_nxt;
      stat_r <= stat_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // frame boundary loading of the selects
  // ----------------------------------------------------------------
  always_comb begin
    yel_sel_nxt = yel_sel_r;
    ais_gen_nxt = ais_gen_r;
    fmt_app_nxt = fmt_app_r;
    ais_det_nxt = ais_det_r;
    if (tx_frame_start) begin
      yel_sel_nxt = ctrl_r[`YEL_HI:`YEL_LO];
      ais_gen_nxt = ctrl_r[`AIS_GEN_HI:`AIS_GEN_LO];
      fmt_app_nxt = alarm_pkg::line_format_t'(fmt_r);
    end
    if (rx_frame_start) begin
      ais_det_nxt = ctrl_r[`AIS_DET_HI:`AIS_DET_LO];
    end
  end

  // ----------------------------------------------------------------
  // esf yellow burst control
  // ----------------------------------------------------------------
  assign esf = (fmt_app_r == alarm_pkg::fmt_esf);
  assign load = tx_frame_start & pend_r &
                (ctrl_r[`YEL_HI:`YEL_LO] == `SEL_FRAMED);

  always_comb begin
    lo_d_nxt = ctrl_r[`YEL_LO];
    // a pulse is remembered until the boundary, which picks it up only if the select still reads framed
    pend_nxt = (ctrl_r[`YEL_LO] & ~lo_d_r) | (pend_r & ~tx_frame_start);
    cnt_nxt = cnt_r;
    if (yel_act_r & pat_done & (cnt_r != 8'h00)) begin
      cnt_nxt = cnt_r - 8'h01;
    end
    if (load) begin
      cnt_nxt = `YEL_BURST;
    end
    demand = esf & ((yel_sel_nxt == `SEL_LEVEL) |
                    (yel_sel_nxt == `SEL_FRAMED) |
                    (cnt_nxt != 8'h00));
    yel_act_nxt = yel_act_r;
    if (~esf) begin
      yel_act_nxt = 1'b0;
    end else if (~yel_act_r & demand) begin
      yel_act_nxt = 1'b1;
    end else if (yel_act_r & pat_done & ~demand) begin
      // while esf holds, stop only on a pattern edge so no half pattern goes out; leaving esf stops at once
      yel_act_nxt = 1'b0;
    end
    if (~esf) begin
      cnt_nxt = 8'h00;
    end
  end

  yellow_pattern_gen u_pattern (
    .clk(clk),
    .rst(rst),
    .hold(~yel_act_r),
    .bit_en(tx_bit_en & tx_fdl_bit),
    .pattern_bit(pat_bit),
    .pattern_done(pat_done)
  );

  // ----------------------------------------------------------------
  // transmit bit insertion
  // ----------------------------------------------------------------
  always_comb begin
    tx_bit = tx_data_in;
    if (fmt_app_r == alarm_pkg::fmt_dm && tx_ybit &&
        yel_sel_r != `SEL_OFF) begin
      tx_bit = 1'b0;
    end
    if (yel_act_r & tx_fdl_bit) begin
      tx_bit = pat_bit;
    end
    case (ais_gen_r)
      `SEL_UNFRAMED: tx_bit = 1'b1;
      `SEL_FRAMED: tx_bit = tx_frame_bit ? tx_bit : 1'b1;
      default: tx_bit = tx_bit;
    endcase
    tx_data_nxt = tx_bit_en ? tx_bit : tx_data_r;
  end

  // ----------------------------------------------------------------
  // receive ais detection
  // ----------------------------------------------------------------
  always_comb begin
    bit_zero = rx_bit_en & ~rx_data &
               ((ais_det_r == `SEL_UNFRAMED) | ~rx_frame_bit);
    zero_nxt = zero_r | bit_zero;
    ones_nxt = ones_r;
    ais_nxt = ais_r;
    if (rx_frame_start) begin
      zero_nxt = bit_zero;
      if (ais_det_r == `SEL_UNFRAMED || ais_det_r == `SEL_FRAMED) begin
        if (zero_r) begin
          ones_nxt = '0;
        end else if (ones_r != AIS_MAX) begin
          ones_nxt = ones_r + AIS_CNT_W'(1);
        end
      end else begin
        ones_nxt = '0;
      end
    end
    ais_nxt = (ones_nxt == AIS_MAX);
  end

  always_comb begin
    ev_set = `EV_RST;
    ev_set[`EV_YEL_START] = ~yel_act_r & yel_act_nxt;
    ev_set[`EV_YEL_END] = yel_act_r & ~yel_act_nxt;
    ev_set[`EV_AIS_ON] = ~ais_r & ais_nxt;
    ev_set[`EV_AIS_OFF] = ais_r & ~ais_nxt;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      yel_sel_r <= `SEL_OFF;
      ais_gen_r <= `SEL_OFF;
      ais_det_r <= `SEL_OFF;
      fmt_app_r <= alarm_pkg::fmt_sf;
      lo_d_r <= 1'b0;
      pend_r <= 1'b0;
      cnt_r <= 8'h00;
      yel_act_r <= 1'b0;
      tx_data_r <= 1'b0;
      zero_r <= 1'b0;
      ones_r <= '0;
      ais_r <= 1'b0;
    end else begin
      yel_sel_r <= yel_sel_nxt;
      ais_gen_r <= ais_gen_nxt;
      ais_det_r <= ais_det_nxt;
      fmt_app_r <= fmt_app_nxt;
      lo_d_r <= lo_d_nxt;
      pend_r <= pend_nxt;
      cnt_r <= cnt_nxt;
      yel_act_r <= yel_act_nxt;
      tx_data_r <= tx_data_nxt;
      zero_r <= zero_nxt;
      ones_r <= ones_nxt;
      ais_r <= ais_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: verification/t1_alarm_props.sv */
// assertion checker for the t1 alarm control block
`default_nettype none
module t1_alarm_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_bit_en,
  input wire logic tx_frame_start,
  input wire logic tx_data_in,
  input wire logic tx_frame_bit,
  input wire logic tx_ybit,
  input wire logic tx_data_out,
  input wire logic rx_frame_start,
  input wire logic ais_detected
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctrl_r, act_r;
  logic [1:0] fmt_r, afmt_r, det_r;
  logic wr, steady;
  assign wr = psel && penable && pwrite;
  // frame-start bits judged only where old and new settings agree
  assign steady = ctrl_r == act_r && fmt_r == afmt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 8'h00;
      act_r <= 8'h00;
      fmt_r <= 2'h0;
      afmt_r <= 2'h0;
      det_r <= 2'h0;
    end else begin
      if (wr && paddr == 8'h00) ctrl_r <= pwdata[7:0];
      if (wr && paddr == 8'h04) fmt_r <= pwdata[1:0];
      if (tx_bit_en && tx_frame_start) begin
        act_r <= ctrl_r;
        afmt_r <= fmt_r;
      end
      if (rx_frame_start) det_r <= ctrl_r[1:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence sf_bit;
    tx_bit_en && afmt_r == 2'h0;
  endsequence
  // ais overrides the y bit, so only judged with ais generation off
  a_dm_ybit_low: assert property (tx_bit_en && steady && tx_ybit &&
    afmt_r == 2'h2 && act_r[5:4] != 2'h0 && !act_r[2] |=> !tx_data_out)
    else $error("y bit not forced low");
  a_ais_off_pass: assert property (sf_bit ##0 (!tx_frame_start &&
    !act_r[2]) |=> tx_data_out == $past(tx_data_in))
    else $error("bit not passed with ais off");
  a_unframed_ones: assert property (sf_bit ##0 (steady &&
    act_r[3:2] == 2'h1) |=> tx_data_out)
    else $error("unframed ais bit not one");
  a_framed_payload: assert property (sf_bit ##0 (steady &&
    act_r[3:2] == 2'h3 && !tx_frame_bit) |=> tx_data_out)
    else $error("framed ais payload not one");
  a_framed_keeps: assert property (sf_bit ##0 (steady &&
    act_r[3:2] == 2'h3 && tx_frame_bit) |=>
    tx_data_out == $past(tx_data_in))
    else $error("framed ais altered framing");
  // a frame start with detection off must clear the flag next cycle
  a_detect_off: assert property (rx_frame_start && !det_r[0] |=>
    !ais_detected)
    else $error("ais flagged while off");
  a_slverr_map: assert property (psel && penable |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
    else $error("error response off map");
  a_ready_high: assert property (pready)
    else $error("ready dropped");
endmodule
bind t1_alarm_signal_control t1_alarm_props i_props (
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .tx_bit_en(tx_bit_en),
  .tx_frame_start(tx_frame_start),
  .tx_data_in(tx_data_in),
  .tx_frame_bit(tx_frame_bit),
  .tx_ybit(tx_ybit),
  .tx_data_out(tx_data_out),
  .rx_frame_start(rx_frame_start),
  .ais_detected(ais_detected)
);
`default_nettype wire

/* File: verification/t1_line_model.sv */
// line-side model: frame timing, bit streams, yellow pattern counter
`default_nettype none
module t1_line_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic [1:0] rx_mode,
  input wire logic tx_data_out,
  output logic tx_bit_en,
  output logic tx_frame_start,
  output logic tx_data_in,
  output logic tx_frame_bit,
  output logic tx_fdl_bit,
  output logic tx_ybit,
  output logic rx_bit_en,
  output logic rx_frame_start,
  output logic rx_data,
  output logic rx_frame_bit,
  output logic [15:0] pat_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // four-bit frame keeps a 255-pattern burst short enough to run:
  // slot 0 framing (sent as zero), 1 data link, 2 payload, 3 y bit
  logic [1:0] slot_r;
  logic [15:0] shift_r, fdl_nxt;
  assign tx_bit_en = 1'h1;
  assign rx_bit_en = 1'h1;
  assign tx_frame_start = slot_r == 2'h0;
  assign tx_frame_bit = slot_r == 2'h0;
  assign rx_frame_start = slot_r == 2'h0;
  assign rx_frame_bit = slot_r == 2'h0;
  assign tx_fdl_bit = slot_r == 2'h1;
  assign tx_ybit = slot_r == 2'h3;
  assign tx_data_in = slot_r[0];
  assign rx_data = rx_mode == 2'h0 ? slot_r[0] :
    (rx_mode == 2'h1 || slot_r != 2'h0);
  assign fdl_nxt = {shift_r[14:0], tx_data_out};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_r <= 2'h0;
      shift_r <= 16'h0000;
      pat_cnt <= 16'h0000;
    end else begin
      slot_r <= slot_r + 2'h1;
      // data-link output bit stands while slot 2 runs
      if (slot_r == 2'h2) shift_r <= fdl_nxt;
      if (clr) pat_cnt <= 16'h0000;
      else if (slot_r == 2'h2 && fdl_nxt == 16'hFF00) begin
        pat_cnt <= pat_cnt + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_t1_alarm_signal_control.sv */
// self-checking bench for the t1 alarm control block
`default_nettype none
module test_t1_alarm_signal_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PAT = 64; // cycles per pattern: 16 link bits, 4-bit frame
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, clr = 1'h0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] rx_mode = 2'h0;
  logic pready, pslverr, irq, tx_data_out, ais_detected, tx_bit_en;
  logic tx_frame_start, tx_data_in, tx_frame_bit, tx_fdl_bit, tx_ybit;
  logic rx_bit_en, rx_frame_start, rx_data, rx_frame_bit;
  logic [15:0] pat_cnt;
  // {expected, line mode, detect select}
  // the first off entry follows a detecting one, so the drop is exercised
  logic [4:0] tbl [5] = '{5'h15, 5'h06, 5'h1B, 5'h09, 5'h04};
  int fails = 0, check_count = 0;
  always #50 clk = ~clk;
  t1_alarm_signal_control i_dut (.*);
  t1_line_model i_line (.*);
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic live(input logic e);
    xf(1'h0, 8'h14, 32'h0);
    chk("yellow live", rd[2], e);
  endtask
  task automatic pulse(input int n);
    clr <= 1'h1;
    xf(1'h1, 8'h00, 32'h30);
    clr <= 1'h0;
    wt(n);
    xf(1'h1, 8'h00, 32'h0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    for (int a = 0; a < 28; a += 4) begin
      xf(1'h0, 8'(a), 32'h0);
      chk("reset value", rd, 32'h0);
      chk("error flag", err, a == 24);
    end
    $display("register reset tests done");
    for (int g = 0; g < 4; g++) begin
      xf(1'h1, 8'h00, 32'(g << 2));
      wt(40);
    end
    xf(1'h1, 8'h04, 32'h2);
    for (int y = 1; y < 4; y++) begin
      xf(1'h1, 8'h00, 32'(y << 4));
      wt(40);
    end
    foreach (tbl[i]) begin
      rx_mode <= tbl[i][3:2];
      xf(1'h1, 8'h00, {30'h0, tbl[i][1:0]});
      wt(40);
      chk("ais detected", ais_detected, tbl[i][4]);
    end
    xf(1'h0, 8'h08, 32'h0);
    chk("ais status", rd, 32'hC);
    $display("ais and data-multiplexed tests done");
    xf(1'h1, 8'h04, 32'h1);
    xf(1'h1, 8'h00, 32'h20);
    wt(20 * PAT);
    live(1'h1);
    xf(1'h1, 8'h00, 32'h0);
    wt(2 * PAT);
    live(1'h0);
    xf(1'h1, 8'h10, 32'hF);
    pulse(2 * PAT);
    wt(256 * PAT);
    chk("burst patterns", pat_cnt, 16'h00FF);
    xf(1'h0, 8'h08, 32'h0);
    chk("status", rd, 32'h3);
    chk("irq masked", irq, 1'h0);
    xf(1'h1, 8'h0C, 32'h3);
    wt(2);
    chk("irq", irq, 1'h1);
    xf(1'h1, 8'h10, 32'h3);
    wt(2);
    chk("irq cleared", irq, 1'h0);
    // look while the bit is still high, not racing its release
    xf(1'h1, 8'h00, 32'h30);
    wt(260 * PAT);
    live(1'h1);
    xf(1'h1, 8'h00, 32'h0);
    wt(2 * PAT);
    live(1'h0);
    pulse(8);
    wt(100 * PAT);
    pulse(8);
    wt(256 * PAT);
    chk("retrigger", pat_cnt inside {16'h00FF, 16'h0100}, 1'h1);
    $display("yellow tests done");
    summarize();
  end
endmodule
`default_nettype wire
